//--- dv/smsp_master.sv
/*
  Behavioural link master that drives the slave port's pins.
  Assumes the core clock as timebase; pins change at its falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module smsp_master (
  // Timebase
  input wire logic clock,
  input wire logic rst,
  // Link pins toward the slave
  output logic csN,
  output logic sck,
  output logic si,
  output logic holdN,
  input wire logic soOut,
  input wire logic soOeN,
  // Received bytes and drive error flag
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic driveBad
);
  logic listen; // Read data expected
  logic lastSo; // Last level the slave drove
  logic line; // Shared data line as seen by the master
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    holdN = 1'b1;
    rxValid = 1'b0;
    rxByte = 8'h00;
    driveBad = 1'b0;
    listen = 1'b0;
    lastSo = 1'b0;
  end
  // Released line shows the inverse of its last level
  always @(posedge clock) if (soOeN === 1'b0) lastSo <= soOut;
  assign line = (soOeN === 1'b0) ? soOut : ~lastSo;
  // Drive outside read data is flagged
  always @(posedge clock) if (!rst && !listen && soOeN !== 1'b1) driveBad = 1'b1;
  // Pause with clock low; clock edges meanwhile must be ignored
  task automatic pause();
    // Let the clock fall settle first; pause changes only once clock is low
    repeat (2) @(negedge clock);
    holdN = 1'b0;
    repeat (6) @(negedge clock);
    if (soOeN !== 1'b1) driveBad = 1'b1;
    repeat (2) begin
      sck = 1'b1;
      repeat (3) @(negedge clock);
      sck = 1'b0;
      repeat (3) @(negedge clock);
    end
    holdN = 1'b1;
    repeat (4) @(negedge clock);
  endtask
  // Shift n bits, most significant first, 320 ns clock period
  task automatic bits(input logic [7:0] tx, input int n, input int pauseAt,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      sck = 1'b0;
      si = tx[7 - i];
      if (i == pauseAt) pause();
      repeat (4) @(negedge clock);
      rx[7 - i] = line;
      sck = 1'b1;
      repeat (3) @(negedge clock);
    end
  endtask
  // One selection; bytes from index rdFrom on are read back
  task automatic frame(input logic m3, input logic [7:0] tx[$], input int nLast,
                       input int pauseAt, input int rdFrom);
    logic [7:0] rx;
    sck = m3; // Idle level selects mode 0 or 3
    @(negedge clock);
    csN = 1'b0; // Fresh select, command first
    repeat (2) @(negedge clock);
    for (int b = 0; b < tx.size(); b++) begin
      repeat ($urandom_range(0, 12)) @(negedge clock); // Clock stalls
      if (b >= rdFrom) listen = 1'b1;
      bits(tx[b], (b == tx.size() - 1) ? nLast : 8, (b == tx.size() - 1) ? pauseAt : -1, rx);
      if (b >= rdFrom) begin
        rxByte = rx;
        rxValid = 1'b1;
        @(negedge clock);
        rxValid = 1'b0;
      end
    end
    @(negedge clock);
    sck = m3;
    @(negedge clock);
    csN = 1'b1;
    repeat (6) @(negedge clock);
    listen = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
/*
  Self-checking bench of the serial memory slave port.
  Assumes the link master model; reads are compared in order of issue.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import smsp_pkg::*;
  logic clock, rst, csN, sck, si, holdN, wpN, soOut, soOeN, rxValid, driveBad;
  logic [7:0] statusByte, rxByte;
  logic [7:0] expQ[$], burst[$], q[$], old[$]; // Expected reads and data sets
  logic [12:0] base, a; // Region base, random address
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  // 25 MHz core clock
  initial clock = 1'b0;
  always #20 clock = ~clock;
  // Device and link master
  smsp_slave u_dut (.clock(clock), .rst(rst), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
    .wpN(wpN), .soOut(soOut), .soOeN(soOeN), .statusByte(statusByte));
  smsp_master u_master (.clock(clock), .rst(rst), .csN(csN), .sck(sck), .si(si),
    .holdN(holdN), .soOut(soOut), .soOeN(soOeN), .rxValid(rxValid), .rxByte(rxByte),
    .driveBad(driveBad));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Oldest note against each byte read
  always @(posedge clock) begin
    if (rxValid === 1'b1) begin
      if (expQ.size() == 0) check({7'h00, rxValid}, 8'h00, "unexpected read");
      else check(rxByte, expQ.pop_front(), "read byte");
    end
  end
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end
  // Single byte command
  task automatic cmd(input logic [7:0] op);
    u_master.frame(1'b0, {op}, 8, -1, 99);
  endtask
  // Array write, optionally opening the latch first
  task automatic wr(input logic [15:0] ad, input logic [7:0] d[$], input logic latch,
                    input int nLast, input int pauseAt);
    if (latch) cmd(OP_WRITE_LATCH_SET);
    u_master.frame(1'b0, {OP_WRITE_ARRAY, ad[15:8], ad[7:0], d}, nLast, pauseAt, 99);
  endtask
  // Array read; expected bytes noted before the frame
  task automatic rd(input logic [15:0] ad, input logic [7:0] e[$], input logic m3,
                    input int pauseAt);
    logic [7:0] tx[$];
    tx = {OP_READ_ARRAY, ad[15:8], ad[7:0]};
    foreach (e[i]) begin
      tx.push_back(8'($urandom));
      expQ.push_back(e[i]);
    end
    u_master.frame(m3, tx, 8, pauseAt, 3);
  endtask
  // Status write behind a latch set
  task automatic wrStatus(input logic [7:0] v);
    cmd(OP_WRITE_LATCH_SET);
    u_master.frame(1'b0, {OP_WRITE_STATUS, v}, 8, -1, 99);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    wpN = 1'b1;
    void'($urandom(32'h7F8E));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check(statusByte, STATUS_RESET, "status after reset");
    cmd(OP_WRITE_LATCH_SET);
    check(statusByte, 8'h02, "latch set");
    cmd(OP_WRITE_LATCH_CLEAR);
    check(statusByte, 8'h00, "latch clear");
    // Burst beyond queue depth, wrapping past the top address
    repeat (10) burst.push_back(8'($urandom));
    wr(16'hFFFA, burst, 1'b1, 8, -1);
    rd(16'h1FFA, burst, 1'b1, -1);
    // Write without latch is refused
    q = {~burst[0], ~burst[1]};
    wr(16'h1FFA, q, 1'b0, 8, -1);
    rd(16'h1FFA, burst[0:1], 1'b0, -1);
    // Second byte cut short at deselect
    wr(16'h1FFA, q, 1'b1, 5, -1);
    burst[0] = q[0];
    rd(16'h1FFA, burst[0:1], 1'b1, -1);
    // Each nonzero block code: byte below the region writes (for all it wraps into the region), region refuses
    for (int c = 1; c <= 3; c++) begin
      base = (c == 1) ? QUARTER_BASE : (c == 2) ? HALF_BASE : 13'h0000;
      old = {8'($urandom), 8'($urandom)};
      wrStatus(8'h00);
      wr({3'h0, base - 13'h0001}, old, 1'b1, 8, -1);
      wrStatus({4'h0, 2'(c), 2'h0});
      check(statusByte, {4'h0, 2'(c), 2'h0}, "block code");
      q = {~old[0], ~old[1]};
      wr({3'h0, base - 13'h0001}, q, 1'b1, 8, -1);
      rd({3'h0, base - 13'h0001}, {(c == 3) ? old[0] : q[0], old[1]}, 1'b0, -1);
    end
    // Guard bit with the protect pin low
    wrStatus(8'h80);
    check(statusByte, 8'h80, "guard set");
    expQ.push_back(8'h80);
    expQ.push_back(8'h80);
    u_master.frame(1'b1, {OP_READ_STATUS, 8'h00, 8'h00}, 8, -1, 1);
    wpN = 1'b0;
    wrStatus(8'h0C);
    check(statusByte & 8'h8C, 8'h80, "status write refused");
    wpN = 1'b1;
    wrStatus(8'h00);
    check(statusByte, 8'h00, "status write taken");
    // Pause in mid byte, writing and reading
    a = 13'($urandom);
    q = {8'($urandom), 8'($urandom)};
    wr({3'h0, a}, q, 1'b1, 8, 3);
    rd({3'h0, a}, q, 1'b0, 5);
    // Unknown commands keep the output released
    for (int i = 0; i < 3; i++) u_master.frame(1'b0, {8'hA5 ^ 8'(i * 90), 8'h03,
      8'h00, 8'h00}, 8, -1, 99);
    repeat (20) @(negedge clock);
    check(8'(expQ.size()), 8'h00, "reads outstanding");
    check({7'h00, driveBad}, 8'h00, "output driven out of turn");
    conclude();
  end
endmodule
`default_nettype wire

//--- rtl/smsp_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module smsp_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  // Storage and pointers with wrap bit
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0] wrPtr_reg;
  logic [PW:0] rdPtr_reg;
  logic doPush;
  logic doPop;

  // Honest full and empty from pointers
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign inReady = !((wrPtr_reg[PW] != rdPtr_reg[PW]) &&
                     (wrPtr_reg[PW-1:0] == rdPtr_reg[PW-1:0]));
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = store[rdPtr_reg[PW-1:0]];

  // Pointer updates
  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  // Data storage
  always_ff @(posedge clock) begin
    if (doPush) begin
      store[wrPtr_reg[PW-1:0]] <= inData;
    end
  end
endmodule
`default_nettype wire

//--- rtl/smsp_mem.sv
/*
  Single-port byte array with registered read data.
  Assumes one access per cycle; write when en and we are both high.
*/
`timescale 1ns/100ps
`default_nettype none
module smsp_mem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  // Clock
  input wire logic clock,
  // Access port
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  // Array cells
  logic [DW-1:0] cells [0:(1<<AW)-1];

  // Write or registered read
  always_ff @(posedge clock) begin
    if (en) begin
      if (we) begin
        cells[addr] <= wdata;
      end else begin
        rdata <= cells[addr];
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/smsp_pkg.sv
/*
  Shared constants and types of the serial memory slave port.
  Assumes nothing of its surroundings; imported by the slave and the testbench.
*/
package smsp_pkg;
  // Array geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // Index of the last bit of a serial byte, and of the first
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  // Write queue depth
  localparam int FIFO_DEPTH = 8;
  // Clock rates; the link is oversampled by the core clock
  localparam int CLOCK_FREQ_MHZ = 25;
  localparam int SCK_MAX_FREQ_MHZ = 16;
  // Command codes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_ARRAY = 8'h03;
  localparam logic [7:0] OP_WRITE_ARRAY = 8'h02;
  // Status byte layout
  localparam int ST_GUARD_BIT = 7;
  localparam int ST_BLOCK_HI = 3;
  localparam int ST_BLOCK_LO = 2;
  localparam int ST_LATCH_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Block protection codes and region bases
  localparam logic [1:0] BLOCK_NONE = 2'h0;
  localparam logic [1:0] BLOCK_QUARTER = 2'h1;
  localparam logic [1:0] BLOCK_HALF = 2'h2;
  localparam logic [12:0] QUARTER_BASE = 13'h1800;
  localparam logic [12:0] HALF_BASE = 13'h1000;
  // Upper address byte bits that are kept
  localparam int ADDR_HI_W = 5;

  // One queued array write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } smsp_wr_t;

  // Command sequencer states
  typedef enum logic [3:0] {
    ST_OPCODE, ST_ADDR_HI, ST_ADDR_LO, ST_WR_DATA, ST_RD_DATA,
    ST_RD_STAT, ST_WR_STAT, ST_DONE, ST_IGNORE
  } smsp_state_t;
endpackage

//--- rtl/smsp_slave.sv
/*
  Serial peripheral slave port of a byte-wide nonvolatile memory.
  Assumes a free-running core clock well above the link clock; all
  link pins arrive asynchronously and are synchronised here.
*/
// Overview of operation
// [RULE1] Deselected: standby, inputs ignored, output released
// [RULE2] Master starts each command with select fall
// [RULE3] Capture on rising, shift out on falling
// [RULE4] Static design; link clock may stop anytime
// [RULE5] Only clock modes zero and three
// [RULE6] Data input sampled on rising edges only
// [RULE7] Output driven only while returning read data
// [RULE8] Guard bit plus low protect blocks status
// [RULE9] Pause freezes transfer, ignores clock and select
// [RULE10] Master changes pause only while clock low
// [RULE11] Each byte committed at once, no busy
// [RULE12] Block protection: upper quarter, half, all
// [RULE13] Latch clear inhibits all writes until set
// [RULE14] Array is 8K bytes, each addressable
// [RULE15] Never drive while receiving; shared line allowed
// [RULE16] First byte after select is the command
// [RULE17] Two address bytes; top three bits ignored
// [RULE18] Most significant bit first both ways
// [RULE19] Unknown command: ignore until next select
// [RULE20] Partial data byte at deselect is discarded
`timescale 1ns/100ps
`default_nettype none
module smsp_slave (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  // Serial output with active-low enable
  output logic soOut,
  output logic soOeN,
  // Current status byte
  output logic [smsp_pkg::DATA_W-1:0] statusByte
);
  import smsp_pkg::*;

  // Two-flop synchronisers, [1] is the only readable stage
  logic [1:0] csSync_reg;
  logic [1:0] sckSync_reg;
  logic [1:0] siSync_reg;
  logic [1:0] holdSync_reg;
  logic [1:0] wpSync_reg;
  // Link edge tracking
  logic sckPrev_reg;
  logic csEff_reg;
  logic holdOk;
  logic sckRise;
  logic sckFall;
  // Receive path
  logic [2:0] bitCnt_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] rxByte;
  logic byteDone;
  // Sequencer
  smsp_state_t state_reg;
  logic isWrite_reg;
  logic wrCmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  // Status fields
  logic writeLatch_reg;
  logic guardBit_reg;
  logic [1:0] block_reg;
  logic statWrite;
  logic blocked;
  logic wrCommit;
  // Write queue
  logic pushValid_reg;
  smsp_wr_t pushData_reg;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  smsp_wr_t fifoOut;
  // Array access
  logic memRead;
  logic memEn;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] memRdData;
  logic fetchPend_reg;
  logic fetchWait_reg;
  logic [7:0] nextByte_reg;
  // Transmit path
  logic [2:0] txCnt_reg;
  logic [7:0] txShift_reg;
  logic [7:0] txSrc;
  logic readState;
  logic driving_reg;

  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      csSync_reg <= 2'h3;
      sckSync_reg <= 2'h0;
      siSync_reg <= 2'h0;
      holdSync_reg <= 2'h3;
      wpSync_reg <= 2'h3;
    end else begin
      csSync_reg <= {csSync_reg[0], csN};
      sckSync_reg <= {sckSync_reg[0], sck};
      siSync_reg <= {siSync_reg[0], si};
      holdSync_reg <= {holdSync_reg[0], holdN};
      wpSync_reg <= {wpSync_reg[0], wpN};
    end
  end

  // Previous clock level, tracked even while paused
  always_ff @(posedge clock) begin
    if (rst) begin
      sckPrev_reg <= 1'b0;
    end else begin
      sckPrev_reg <= sckSync_reg[1]; // RULE4
    end
  end

  // Select is frozen while paused
  always_ff @(posedge clock) begin
    if (rst) begin
      csEff_reg <= 1'b1;
    end else if (holdOk) begin // RULE9
      csEff_reg <= csSync_reg[1];
    end
  end

  // Edges count only when selected and not paused
  assign holdOk = holdSync_reg[1];
  assign sckRise = holdOk && !csEff_reg && sckSync_reg[1] && !sckPrev_reg; // RULE1 RULE5
  assign sckFall = holdOk && !csEff_reg && !sckSync_reg[1] && sckPrev_reg; // RULE9

  // Incoming byte, most significant bit first
  assign rxByte = {rxShift_reg[6:0], siSync_reg[1]}; // RULE18
  assign byteDone = sckRise && (bitCnt_reg == BYTE_LAST);

  // Bit counter, cleared while deselected
  always_ff @(posedge clock) begin
    if (rst || csEff_reg) begin
      bitCnt_reg <= BIT_FIRST; // RULE20
    end else if (sckRise) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
    end
  end

  // Input shifter, loads only on rising edges
  always_ff @(posedge clock) begin
    if (rst) begin
      rxShift_reg <= 8'h00;
    end else if (sckRise) begin
      rxShift_reg <= rxByte; // RULE3 RULE6
    end
  end

  // Command sequencer
  always_ff @(posedge clock) begin
    if (rst || csEff_reg) begin
      state_reg <= ST_OPCODE; // RULE2 RULE16
    end else if (byteDone) begin
      unique case (state_reg)
        // Decode command byte
        ST_OPCODE: begin
          case (rxByte)
            OP_WRITE_LATCH_SET: state_reg <= ST_DONE;
            OP_WRITE_LATCH_CLEAR: state_reg <= ST_DONE;
            OP_READ_STATUS: state_reg <= ST_RD_STAT;
            OP_WRITE_STATUS: state_reg <= ST_WR_STAT;
            OP_READ_ARRAY: state_reg <= ST_ADDR_HI;
            OP_WRITE_ARRAY: state_reg <= ST_ADDR_HI;
            default: state_reg <= ST_IGNORE; // RULE19
          endcase
        end
        // Address bytes
        ST_ADDR_HI: state_reg <= ST_ADDR_LO;
        ST_ADDR_LO: state_reg <= isWrite_reg ? ST_WR_DATA : ST_RD_DATA;
        // Status write is one byte
        ST_WR_STAT: state_reg <= ST_DONE;
        // Streaming and idle states hold
        ST_WR_DATA: state_reg <= ST_WR_DATA;
        ST_RD_DATA: state_reg <= ST_RD_DATA;
        ST_RD_STAT: state_reg <= ST_RD_STAT;
        ST_DONE: state_reg <= ST_DONE;
        ST_IGNORE: state_reg <= ST_IGNORE;
      endcase
    end
  end

  // Command kind flags
  always_ff @(posedge clock) begin
    if (rst || csEff_reg) begin
      isWrite_reg <= 1'b0;
      wrCmd_reg <= 1'b0;
    end else if (byteDone && state_reg == ST_OPCODE) begin
      isWrite_reg <= rxByte == OP_WRITE_ARRAY;
      wrCmd_reg <= (rxByte == OP_WRITE_ARRAY) || (rxByte == OP_WRITE_STATUS);
    end
  end

  // Address pointer, wraps over 13 bits
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg <= '0;
    end else if (byteDone && state_reg == ST_ADDR_HI) begin
      addr_reg[ADDR_W-1:8] <= rxByte[ADDR_HI_W-1:0]; // RULE17
    end else if (byteDone && state_reg == ST_ADDR_LO) begin
      addr_reg[7:0] <= rxByte;
    end else if (byteDone && state_reg == ST_WR_DATA) begin
      addr_reg <= addr_reg + 1'b1; // RULE14
    end else if (sckFall && state_reg == ST_RD_DATA && txCnt_reg == BIT_FIRST) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // Write latch: set, clear, and cleared after a write command ends
  always_ff @(posedge clock) begin
    if (rst) begin
      writeLatch_reg <= 1'b0;
    end else if (byteDone && state_reg == ST_OPCODE && rxByte == OP_WRITE_LATCH_SET) begin
      writeLatch_reg <= 1'b1;
    end else if (byteDone && state_reg == ST_OPCODE && rxByte == OP_WRITE_LATCH_CLEAR) begin
      writeLatch_reg <= 1'b0; // RULE13
    end else if (csEff_reg && wrCmd_reg) begin
      writeLatch_reg <= 1'b0;
    end
  end

  // Status write permitted only with latch and without pin guard
  assign statWrite = byteDone && state_reg == ST_WR_STAT && writeLatch_reg &&
                     !(guardBit_reg && !wpSync_reg[1]); // RULE8 RULE13

  // Writable status fields
  always_ff @(posedge clock) begin
    if (rst) begin
      guardBit_reg <= STATUS_RESET[ST_GUARD_BIT];
      block_reg <= STATUS_RESET[ST_BLOCK_HI:ST_BLOCK_LO];
    end else if (statWrite) begin
      guardBit_reg <= rxByte[ST_GUARD_BIT];
      block_reg <= rxByte[ST_BLOCK_HI:ST_BLOCK_LO];
    end
  end

  // Protected region check
  always_comb begin
    unique case (block_reg)
      BLOCK_NONE: blocked = 1'b0;
      BLOCK_QUARTER: blocked = addr_reg >= QUARTER_BASE; // RULE12
      BLOCK_HALF: blocked = addr_reg >= HALF_BASE;
      default: blocked = 1'b1;
    endcase
  end

  // Whole byte received and allowed into the array
  assign wrCommit = byteDone && state_reg == ST_WR_DATA && writeLatch_reg && !blocked; // RULE11

  // Pending queue entry, held until the queue takes it
  always_ff @(posedge clock) begin
    if (rst) begin
      pushValid_reg <= 1'b0;
      pushData_reg <= '0;
    end else if (wrCommit) begin
      pushValid_reg <= 1'b1;
      pushData_reg <= '{addr: addr_reg, data: rxByte};
    end else if (fifoInReady) begin
      pushValid_reg <= 1'b0;
    end
  end

  // Write queue between link and array
  smsp_fifo #(
    .WIDTH($bits(smsp_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .inValid(pushValid_reg),
    .inReady(fifoInReady),
    .inData(pushData_reg),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  // Reads wait for queued writes; a read stalls the queue drain
  assign memRead = fetchPend_reg && !pushValid_reg && !fifoOutValid;
  assign fifoOutReady = !memRead;
  assign memEn = memRead || fifoOutValid;
  assign memAddr = memRead ? addr_reg : fifoOut.addr;

  // Byte array
  smsp_mem #(
    .AW(ADDR_W),
    .DW(DATA_W)
  ) u_mem (
    .clock(clock),
    .en(memEn),
    .we(!memRead),
    .addr(memAddr),
    .wdata(fifoOut.data),
    .rdata(memRdData)
  );

  // Read-ahead request after address and after each byte loaded
  always_ff @(posedge clock) begin
    if (rst) begin
      fetchPend_reg <= 1'b0;
    end else if (byteDone && state_reg == ST_ADDR_LO && !isWrite_reg) begin
      fetchPend_reg <= 1'b1;
    end else if (sckFall && state_reg == ST_RD_DATA && txCnt_reg == BIT_FIRST) begin
      fetchPend_reg <= 1'b1;
    end else if (memRead) begin
      fetchPend_reg <= 1'b0;
    end
  end

  // Capture fetched byte
  always_ff @(posedge clock) begin
    if (rst) begin
      fetchWait_reg <= 1'b0;
      nextByte_reg <= 8'h00;
    end else begin
      fetchWait_reg <= memRead;
      if (fetchWait_reg) begin
        nextByte_reg <= memRdData;
      end
    end
  end

  // Byte to send next
  assign readState = state_reg == ST_RD_DATA || state_reg == ST_RD_STAT;
  assign txSrc = (state_reg == ST_RD_STAT) ? statusByte : nextByte_reg;

  // Output shifter, moves only on falling edges
  always_ff @(posedge clock) begin
    if (rst || csEff_reg) begin
      txCnt_reg <= BIT_FIRST;
      txShift_reg <= 8'h00;
      driving_reg <= 1'b0;
    end else if (sckFall && readState) begin
      txCnt_reg <= txCnt_reg + 1'b1;
      driving_reg <= 1'b1; // RULE7
      if (txCnt_reg == BIT_FIRST) begin
        txShift_reg <= {txSrc[6:0], 1'b0};
      end else begin
        txShift_reg <= {txShift_reg[6:0], 1'b0};
      end
    end
  end

  // Serial output bit, most significant first
  always_ff @(posedge clock) begin
    if (rst) begin
      soOut <= 1'b1;
    end else if (sckFall && readState) begin
      soOut <= (txCnt_reg == BIT_FIRST) ? txSrc[7] : txShift_reg[7]; // RULE3 RULE18
    end
  end

  // Output enable, released when deselected or paused
  always_ff @(posedge clock) begin
    if (rst) begin
      soOeN <= 1'b1;
    end else begin
      soOeN <= !(driving_reg && readState && holdOk && !csEff_reg); // RULE1 RULE7 RULE15
    end
  end

  // Status byte image
  always_ff @(posedge clock) begin
    if (rst) begin
      statusByte <= STATUS_RESET;
    end else begin
      statusByte <= STATUS_RESET;
      statusByte[ST_GUARD_BIT] <= guardBit_reg;
      statusByte[ST_BLOCK_HI:ST_BLOCK_LO] <= block_reg;
      statusByte[ST_LATCH_BIT] <= writeLatch_reg;
    end
  end

  // Checks
  standby_hiz_a: assert property (@(posedge clock) disable iff (rst) // RULE1
    csEff_reg |=> soOeN) else $error("output driven while deselected");
  pause_hiz_a: assert property (@(posedge clock) disable iff (rst) // RULE9
    !holdOk |=> soOeN && $stable(bitCnt_reg)) else $error("activity during pause");
  out_edge_a: assert property (@(posedge clock) disable iff (rst) // RULE3
    !$stable(soOut) |-> $past(sckFall)) else $error("output moved off a falling edge");
  sample_rise_a: assert property (@(posedge clock) disable iff (rst) // RULE6
    !$stable(rxShift_reg) |-> $past(sckRise)) else $error("input sampled off a rising edge");
  status_guard_a: assert property (@(posedge clock) disable iff (rst) // RULE8
    (guardBit_reg && !wpSync_reg[1]) |=> $stable(block_reg) && guardBit_reg)
    else $error("status changed while guarded");
  commit_fast_a: assert property (@(posedge clock) disable iff (rst) // RULE11
    wrCommit |=> pushValid_reg ##[1:4] !fifoOutValid) else $error("write not committed");
  latch_gate_a: assert property (@(posedge clock) disable iff (rst) // RULE13
    wrCommit || statWrite |-> writeLatch_reg) else $error("write without latch");
  block_guard_a: assert property (@(posedge clock) disable iff (rst) // RULE12
    wrCommit |-> !(block_reg == BLOCK_HALF && addr_reg >= HALF_BASE))
    else $error("write into protected half");
  rx_hiz_a: assert property (@(posedge clock) disable iff (rst) // RULE15
    !readState |=> soOeN) else $error("output driven while receiving");
  ignore_hiz_a: assert property (@(posedge clock) disable iff (rst) // RULE19
    state_reg == ST_IGNORE |-> !wrCommit && !statWrite && soOeN)
    else $error("activity after unknown command");
endmodule
`default_nettype wire
